// >>> design/sbrp_defines.svh
// constants for the slow-bus register access port
// Notes on behaviour
// - data path is one byte wide; each data phase moves one byte.
// - single bytes and multi-byte bursts accepted, reads and writes.
// - both bytes of the 16-bit config word may move in one burst.
// - reads wait three cycles before first byte, two before each next.
// - writes wait two cycles before first byte, one before each next.
// - leave idle on strobe low and select; direction picks path.
// - ready low throughout every data phase and at no other time.
// - early ready raised in the cycle before each data phase.
// - write data phase decodes two byte selects into one of four strobes.
// - strobed register captures bus byte on the next rising edge.
// - reads mux the addressed register byte and drive it on the bus.
// - read drive only during reads of this port, while bus is free.
// - transceiver controls come from outside; never drive against it.
`ifndef SBRP_DEFINES_SVH
`define SBRP_DEFINES_SVH

`define SBRP_DATA_W 8
`define SBRP_NUM_REGS 4
`define SBRP_WAIT_W 2
`define SBRP_RD_WAIT_FIRST 2'h3
`define SBRP_RD_WAIT_NEXT 2'h2
`define SBRP_WR_WAIT_FIRST 2'h2
`define SBRP_WR_WAIT_NEXT 2'h1
`define SBRP_WAIT_LAST 2'h1
`define SBRP_REG_RESET 8'h00
`define SBRP_BEAT_W 3
`define SBRP_BEAT_ZERO 3'h0
`define SBRP_BEAT_ONE 3'h1
`define SBRP_XCVR_TO_SLOW 1'b1

`endif

// >>> design/sbrp_pkg.sv
// types and helpers shared by the slow-bus register access port
`include "sbrp_defines.svh"

package sbrp_pkg;

    typedef enum logic [1:0] {
        SBRP_ST_IDLE,
        SBRP_ST_WAIT,
        SBRP_ST_DATA
    } sbrp_state_t;

    // processor side of the slow bus, sampled on ref_clk_i
    typedef struct packed {
        logic addr_strobe_n;
        logic port_sel;
        logic write_not_read;
        logic burst_last_n;
        logic byte_sel_bit1_n;
        logic byte_sel_bit0_n;
    } sbrp_bus_t;

    // transceiver controls made by neighbouring logic
    typedef struct packed {
        logic xcvr_direction;
        logic xcvr_output_enable_n;
    } sbrp_xcvr_t;

    typedef logic [`SBRP_DATA_W-1:0] sbrp_byte_t;
    typedef logic [`SBRP_NUM_REGS-1:0][`SBRP_DATA_W-1:0] sbrp_regs_t;

    // active-low byte selects into a register index
    function automatic logic [1:0] sbrp_reg_index(input sbrp_bus_t b);
        sbrp_reg_index = {~b.byte_sel_bit1_n, ~b.byte_sel_bit0_n};
    endfunction

endpackage

// >>> design/sbrp_regfile.sv
// the four byte registers reached through the access port
`timescale 1ns/1ps
`include "sbrp_defines.svh"

module sbrp_regfile
    import sbrp_pkg::*;
(
    input wire logic ref_clk_i, // processor clock
    input wire logic reset_n_i, // sync reset, active low
    input wire logic [`SBRP_NUM_REGS-1:0] wr_strobe_i, // one-hot load
    input wire sbrp_pkg::sbrp_byte_t wr_data_i, // byte from bus
    output sbrp_pkg::sbrp_regs_t regs_o // register contents
);
    import sbrp_pkg::*;

    sbrp_regs_t regs_ff;
    sbrp_regs_t nxt_regs;

    always_comb begin
        nxt_regs = regs_ff;
        for (int i = 0; i < `SBRP_NUM_REGS; i++) begin
            if (wr_strobe_i[i]) begin
                nxt_regs[i] = wr_data_i;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < `SBRP_NUM_REGS; i++) begin
                regs_ff[i] <= `SBRP_REG_RESET;
            end
        end else begin
            regs_ff <= nxt_regs;
        end
    end

    assign regs_o = regs_ff;

endmodule

// >>> design/sbrp_port.sv
// slow-bus register access controller with its byte registers
`timescale 1ns/1ps
`include "sbrp_defines.svh"

module sbrp_port
    import sbrp_pkg::*;
(
    input wire logic ref_clk_i, // processor clock
    input wire logic reset_n_i, // sync reset, active low
    input wire sbrp_pkg::sbrp_bus_t bus_i, // processor control
    input wire sbrp_pkg::sbrp_xcvr_t xcvr_i, // transceiver controls
    input wire sbrp_pkg::sbrp_byte_t data_i, // slow data bus in
    output sbrp_pkg::sbrp_byte_t data_o, // slow data bus out
    output logic data_oe_n_o, // bus drive enable, low drives
    output logic ready_n_o, // ready to processor
    output logic early_ready_o, // next cycle is data phase
    output logic in_data_phase_o, // data phase in progress
    output logic [`SBRP_NUM_REGS-1:0] wr_strobe_o, // register loads
    output sbrp_pkg::sbrp_regs_t regs_o, // register contents
    output logic [2*`SBRP_DATA_W-1:0] config_word_o, // regs 1:0
    output logic busy_o, // access under way
    output logic [`SBRP_BEAT_W-1:0] beat_count_o // bytes done in burst
);
    import sbrp_pkg::*;

    // the processor bus is on ref_clk_i, so no synchronisers are used
    sbrp_state_t state_ff;
    sbrp_state_t nxt_state;
    logic [`SBRP_WAIT_W-1:0] wait_ff;
    logic [`SBRP_WAIT_W-1:0] nxt_wait;
    logic write_ff;
    logic nxt_write;
    logic [`SBRP_BEAT_W-1:0] beat_ff;
    logic [`SBRP_BEAT_W-1:0] nxt_beat;
    logic access_start;

    assign access_start = !bus_i.addr_strobe_n && bus_i.port_sel;

    // ---- access sequencer ----
    always_comb begin
        nxt_state = state_ff;
        nxt_wait = wait_ff;
        nxt_write = write_ff;
        nxt_beat = beat_ff;
        case (state_ff)
            SBRP_ST_IDLE: begin
                if (access_start) begin
                    nxt_state = SBRP_ST_WAIT;
                    nxt_write = bus_i.write_not_read;
                    nxt_beat = `SBRP_BEAT_ZERO;
                    if (bus_i.write_not_read) begin
                        nxt_wait = `SBRP_WR_WAIT_FIRST;
                    end else begin
                        nxt_wait = `SBRP_RD_WAIT_FIRST;
                    end
                end
            end
            SBRP_ST_WAIT: begin
                if (wait_ff == `SBRP_WAIT_LAST) begin
                    nxt_state = SBRP_ST_DATA;
                end else begin
                    nxt_wait = wait_ff - `SBRP_WAIT_LAST;
                end
            end
            SBRP_ST_DATA: begin
                // one byte per data phase on the 8-bit path
                nxt_beat = beat_ff + `SBRP_BEAT_ONE;
                if (bus_i.burst_last_n) begin
                    // bursts keep going, e.g. both config bytes
                    nxt_state = SBRP_ST_WAIT;
                    if (write_ff) begin
                        nxt_wait = `SBRP_WR_WAIT_NEXT;
                    end else begin
                        nxt_wait = `SBRP_RD_WAIT_NEXT;
                    end
                end else begin
                    nxt_state = SBRP_ST_IDLE;
                end
            end
            default: begin
                nxt_state = SBRP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            state_ff <= SBRP_ST_IDLE;
            wait_ff <= `SBRP_WR_WAIT_NEXT;
            write_ff <= 1'b0;
            beat_ff <= `SBRP_BEAT_ZERO;
        end else begin
            state_ff <= nxt_state;
            wait_ff <= nxt_wait;
            write_ff <= nxt_write;
            beat_ff <= nxt_beat;
        end
    end

    // ---- handshake to the processor ----
    assign in_data_phase_o = (state_ff == SBRP_ST_DATA);
    assign ready_n_o = !in_data_phase_o;
    // lets the shared ready logic line up with the data phase
    assign early_ready_o = (state_ff == SBRP_ST_WAIT) &&
                           (nxt_state == SBRP_ST_DATA);
    assign busy_o = (state_ff != SBRP_ST_IDLE);
    assign beat_count_o = beat_ff;

    // ---- write strobes ----
    always_comb begin
        wr_strobe_o = '0;
        if (in_data_phase_o && write_ff) begin
            wr_strobe_o[sbrp_reg_index(bus_i)] = 1'b1;
        end
    end

    sbrp_regfile u_regfile (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .wr_strobe_i (wr_strobe_o),
        .wr_data_i (data_i),
        .regs_o (regs_o)
    );

    assign config_word_o = {regs_o[1], regs_o[0]};

    // ---- read data path ----
    sbrp_byte_t rd_data_ff;
    sbrp_byte_t nxt_rd_data;
    logic drive_ff;
    logic nxt_drive;

    // byte selects are stable during the waits, so the mux settles
    // before the data phase on every byte of a burst
    always_comb begin
        nxt_rd_data = regs_o[sbrp_reg_index(bus_i)];
        nxt_drive = (nxt_state != SBRP_ST_IDLE) && !nxt_write;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            rd_data_ff <= `SBRP_REG_RESET;
            drive_ff <= 1'b0;
        end else begin
            rd_data_ff <= nxt_rd_data;
            drive_ff <= nxt_drive;
        end
    end

    assign data_o = rd_data_ff;
    // live gate: drivers drop at once if the transceiver turns toward
    // the slow bus, at the cost of a combinational path to the pad
    assign data_oe_n_o = !(drive_ff && (xcvr_i.xcvr_direction !=
                           `SBRP_XCVR_TO_SLOW));

endmodule

// >>> test/sbrp_port_sva.sv
// slow-bus port assertions
`timescale 1ns/1ps
module sbrp_port_sva
    import sbrp_pkg::*;
(
    input wire logic ref_clk_i, // clock
    input wire logic reset_n_i, // reset
    input wire sbrp_pkg::sbrp_bus_t bus_i, // control
    input wire sbrp_pkg::sbrp_xcvr_t xcvr_i, // xcvr
    input wire logic data_oe_n_o, // drive
    input wire logic ready_n_o, // ready
    input wire logic early_ready_o, // early
    input wire logic [3:0] wr_strobe_o, // loads
    input wire logic busy_o // busy
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    wire dp = !ready_n_o;
    wire wr = bus_i.write_not_read;
    wire st = !busy_o && !bus_i.addr_strobe_n && bus_i.port_sel;
    wire [1:0] ix = {~bus_i.byte_sel_bit1_n, ~bus_i.byte_sel_bit0_n};
    property p_early; dp == $past(early_ready_o); endproperty
    a_early: assert property (p_early) else $error("early");
    property p_rd1; st && !wr |=> !dp [*3] ##1 dp; endproperty
    a_rd1: assert property (p_rd1) else $error("rd1");
    property p_wr1; st && wr |=> !dp [*2] ##1 dp; endproperty
    a_wr1: assert property (p_wr1) else $error("wr1");
    property p_rdn; dp && !wr && bus_i.burst_last_n |=> !dp [*2] ##1 dp;
    endproperty
    a_rdn: assert property (p_rdn) else $error("rdn");
    property p_wrn; dp && wr && bus_i.burst_last_n |=> !dp ##1 dp;
    endproperty
    a_wrn: assert property (p_wrn) else $error("wrn");
    property p_end; dp && !bus_i.burst_last_n |=> !busy_o; endproperty
    a_end: assert property (p_end) else $error("end");
    property p_strb; wr_strobe_o == (dp && wr ? 4'h1 << ix : 4'h0);
    endproperty
    a_strb: assert property (p_strb) else $error("strb");
    // drive only on reads with the transceiver turned round
    property p_oe; !data_oe_n_o |-> !wr && busy_o && !xcvr_i.xcvr_direction;
    endproperty
    a_oe: assert property (p_oe) else $error("oe");
    cover property (st && !wr);
    cover property (dp && wr && bus_i.burst_last_n);
    cover property (dp && !data_oe_n_o);
endmodule

bind sbrp_port sbrp_port_sva sbrp_port_sva_i (.ref_clk_i, .reset_n_i,
    .bus_i, .xcvr_i, .data_oe_n_o, .ready_n_o, .early_ready_o,
    .wr_strobe_o, .busy_o);

// >>> test/sbrp_xcvr_model.sv
// host-side model steering the bus transceiver
`timescale 1ns/1ps
module sbrp_xcvr_model
    import sbrp_pkg::*;
(
    input wire logic ref_clk_i, // clock
    input wire logic reset_n_i, // reset
    input wire sbrp_pkg::sbrp_bus_t bus_i, // host control
    input wire logic ready_n_i, // device ready
    output sbrp_pkg::sbrp_xcvr_t xcvr_o // transceiver
);
    logic rd_ff;
    wire go = !bus_i.addr_strobe_n && bus_i.port_sel;
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i || (!ready_n_i && !bus_i.burst_last_n))
            rd_ff <= 1'b0;
        else if (go && !bus_i.write_not_read)
            rd_ff <= 1'b1;
    end
    // turned round for the whole read only
    assign xcvr_o = {!rd_ff, 1'b0};
endmodule

// >>> test/testbench.sv
// bench for the slow-bus register access port
`timescale 1ns/1ps
module testbench;
    import sbrp_pkg::*;
    logic clk = 0, rst_n = 0, oe_n, rdy_n, busy;
    logic [3:0] strb;
    logic early, idp;
    logic [2:0] beat;
    logic [15:0] cfg;
    sbrp_bus_t bus = 6'h27;
    sbrp_xcvr_t xc;
    sbrp_byte_t din = 8'h00, dout;
    sbrp_regs_t regs;
    sbrp_byte_t er [4] = '{default: 8'h00};
    int err_total = 0, samples_checked = 0, cyc = 0;
    initial forever #2.5 clk = ~clk;
    sbrp_port sbrp_port_i (.ref_clk_i(clk), .reset_n_i(rst_n), .bus_i(bus),
        .xcvr_i(xc), .data_i(din), .data_o(dout), .data_oe_n_o(oe_n),
        .ready_n_o(rdy_n), .early_ready_o(early), .in_data_phase_o(idp),
        .wr_strobe_o(strb), .regs_o(regs), .config_word_o(cfg),
        .busy_o(busy), .beat_count_o(beat));
    sbrp_xcvr_model sbrp_xcvr_model_i (.ref_clk_i(clk), .reset_n_i(rst_n),
        .bus_i(bus), .ready_n_i(rdy_n), .xcvr_o(xc));
    task automatic chk(string s, logic [15:0] e, logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        if (++cyc == 3000) begin
            err_total++;
            test_done();
        end
    end
    // one access; selects change only after the previous data phase
    task automatic xfer(logic wr, int n, logic [1:0] ix, sbrp_byte_t d);
        int w;
        logic e;
        @(negedge clk);
        for (int k = 0; k < n; k++) begin
            bus = '{k > 0, 1'b1, wr, k < n - 1, ~ix[1], ~ix[0]};
            din = wr ? d : ~din;
            w = (k > 0);
            e = early;
            repeat (6) begin
                @(negedge clk);
                bus.addr_strobe_n = 1'b1;
                if (rdy_n === 1'b0) break;
                e = early;
                w++;
            end
            chk("waits", k ? (wr ? 1 : 2) : (wr ? 2 : 3),
                w);
            chk("early", 1, e);
            chk("phase", 1, idp);
            if (wr) chk("strobe", 4'h1 << ix, strb);
            else chk("rdata", er[ix], dout);
            if (!wr) chk("drive", 0, oe_n);
            if (wr) er[ix] = din;
            @(negedge clk);
            chk("busy", k < n - 1, busy);
            chk("beat", k + 1, beat);
            chk("reg", er[ix], regs[ix]);
            ix++;
            d += 8'h11;
        end
    endtask
    task automatic t_refuse();
        chk("ready", 1, rdy_n);
        chk("drive", 1, oe_n);
        @(negedge clk);
        bus = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
        repeat (5) begin
            @(negedge clk);
            bus.addr_strobe_n = 1'b1;
            chk("busy", 0, busy);
        end
    endtask
    task automatic t_burst();
        xfer(1, 4, 2'h1, 8'h3c);
        xfer(0, 4, 2'h3, 8'h00);
        xfer(1, 2, 2'h0, 8'ha5);
        chk("cfg", {er[1], er[0]}, cfg);
    endtask
    task automatic t_single();
        for (int i = 0; i < 4; i++)
            xfer(i[0], 1, i[1:0], 8'hc0);
    endtask
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        t_refuse();
        t_burst();
        t_single();
        test_done();
    end
endmodule
